// ===== logic/nfca_pkg.sv
// Shared constants for the NVM-driven function configuration autoloader
//
// What this block does
// - Boot word bit 15 disables keyboard-style ROM BAR.
// - Boot word bit 14 disables storage ROM BAR.
// - Boot word bit 13 disables network ROM BAR.
// - Boot word bit 12 disables network flash window.
// - Keyboard-style class low word: subclass, interface.
// - Keyboard-style class high word low byte: base class.
// - Port 0 uses low addresses, port 1 high, except the boot word, which both ports read at the low address.
// - USB function device ID override loaded.
// - Block-transfer device ID override loaded.
// - USB function subsystem ID loaded, default zero.
// - Block-transfer subsystem ID loaded, default zero.
// - Block-transfer class low word: middle, low byte.
// - Block-transfer class high word: base class.
// - Active power fields reported while in D0.
// - Sleep power fields reported while in D3.
// - Same value for consumption and dissipation.
package nfca_pkg;

  // =====
  // Word sequence
  localparam int unsigned        NUM_WORDS = 11;
  localparam int unsigned        AW        = 9;           // NVM word address width
  localparam logic [3:0]         W_BOOT    = 4'h0;        // Boot expansion size
  localparam logic [3:0]         W_KCL     = 4'h1;        // Keyboard-style class low
  localparam logic [3:0]         W_KCH     = 4'h2;        // Keyboard-style class high
  localparam logic [3:0]         W_UDEV    = 4'h3;        // USB function device ID
  localparam logic [3:0]         W_BDEV    = 4'h4;        // Block-transfer device ID
  localparam logic [3:0]         W_USUB    = 4'h5;        // USB function subsystem ID
  localparam logic [3:0]         W_BSUB    = 4'h6;        // Block-transfer subsystem ID
  localparam logic [3:0]         W_BCL     = 4'h7;        // Block-transfer class low
  localparam logic [3:0]         W_BCH     = 4'h8;        // Block-transfer class high
  localparam logic [3:0]         W_PD0     = 4'h9;        // Active power word
  localparam logic [3:0]         W_PD3     = 4'ha;        // Sleep power word
  localparam logic [3:0]         W_LAST    = 4'ha;

  // Addresses for network port 0 and port 1
  localparam logic [AW-1:0] ADDR_P0 [NUM_WORDS] = '{9'h04c, 9'h04e, 9'h04f, 9'h050, 9'h052, 9'h053,
                                                    9'h055, 9'h057, 9'h058, 9'h059, 9'h05a};
  localparam logic [AW-1:0] ADDR_P1 [NUM_WORDS] = '{9'h04c, 9'h10e, 9'h10f, 9'h110, 9'h112, 9'h113,
                                                    9'h115, 9'h117, 9'h118, 9'h119, 9'h11a};

  // =====
  // Field positions
  localparam int unsigned        B_KBD_OFF   = 15;
  localparam int unsigned        B_STOR_OFF  = 14;
  localparam int unsigned        B_NET_OFF   = 13;
  localparam int unsigned        B_FLASH_OFF = 12;
  localparam int unsigned        PW_USB_LO   = 10;        // Bits 14:10
  localparam int unsigned        PW_RSV_LO   = 5;         // Bits 9:5
  localparam int unsigned        PW_BT_LO    = 0;         // Bits 4:0
  localparam int unsigned        PW_MARK     = 15;

  // =====
  // Hardware defaults
  localparam logic [3:0]         BOOT_DEF    = 4'he;      // Bits 15:12 = 1,1,1,0
  localparam logic [23:0]        KBD_CLS_DEF = 24'h0c0701;
  localparam logic [23:0]        BT_CLS_DEF  = 24'h0c0702;
  localparam logic [15:0]        SUB_DEF     = 16'h0000;
  localparam logic [4:0]         PWR_DEF     = 5'h00;

  // =====
  // APB register byte addresses
  localparam logic [7:0]         A_CTRL   = 8'h00;
  localparam logic [7:0]         A_STAT   = 8'h04;
  localparam logic [7:0]         A_BOOT   = 8'h08;
  localparam logic [7:0]         A_KCLS   = 8'h0c;
  localparam logic [7:0]         A_BCLS   = 8'h10;
  localparam logic [7:0]         A_UIDS   = 8'h14;
  localparam logic [7:0]         A_BIDS   = 8'h18;
  localparam logic [7:0]         A_PWR    = 8'h1c;
  localparam int unsigned        C_RELOAD = 0;            // Write-one reload strobe
  localparam int unsigned        C_PORT   = 1;            // Network port select

  typedef enum logic [1:0] {
    NFCA_IDLE,
    NFCA_FETCH,
    NFCA_READY
  } nfca_state_t;

endpackage

// ===== logic/nfca_top.sv
// Autoloader: fetches NVM words after reset and presents function config fields
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module nfca_top #(
  parameter logic [15:0] USB_DEV_ID_DEF = 16'h0a5a,   // Arbitrary value
  parameter logic [15:0] BT_DEV_ID_DEF  = 16'h0a5b    // Arbitrary value
) (
  input  wire logic                          pclk,                  // Clock, 200 MHz
  input  wire logic                          presetn,               // Async reset, active low
  input  wire logic                          ce,                    // Clock enable, freezes all state
  // APB slave
  input  wire logic                          psel,                  // Select
  input  wire logic                          penable,               // Access phase
  input  wire logic                          pwrite,                // Write
  input  wire logic [7:0]                    paddr,                 // Byte address
  input  wire logic [31:0]                   pwdata,                // Write data
  output logic                               pready,                // Ready
  output logic                               pslverr,               // Unmapped address
  output logic [31:0]                        prdata,                // Read data
  // NVM word reader
  output logic                               nvm_req,               // Read request, held until ack
  output logic [nfca_pkg::AW-1:0]            nvm_addr,              // Word address
  input  wire logic                          nvm_ack,               // Data valid pulse
  input  wire logic [15:0]                   nvm_data,              // Word read
  // Power state of the functions
  input  wire logic                          usb_in_d3,             // USB function in D3
  input  wire logic                          bt_in_d3,              // Block-transfer function in D3
  // Configuration space fields
  output logic                               cfg_ready,             // Load finished
  output logic                               kbd_style_rom_bar_off, // Keyboard-style ROM BAR off
  output logic                               storage_rom_bar_off,   // Storage ROM BAR off
  output logic                               net_rom_bar_off,       // Network ROM BAR off
  output logic                               net_flash_window_off,  // Network flash BAR off
  output logic [23:0]                        kbd_class_code,        // Keyboard-style class code
  output logic [23:0]                        bt_class_code,         // Block-transfer class code
  output logic [15:0]                        usb_dev_id,            // Function 5 device ID
  output logic [15:0]                        usb_subsys_id,         // Function 5 subsystem ID
  output logic [15:0]                        bt_dev_id,             // Function 7 device ID
  output logic [15:0]                        bt_subsys_id,          // Function 7 subsystem ID
  output logic [4:0]                         usb_pm_data,           // Function 5 PM data value
  output logic [4:0]                         bt_pm_data             // Function 7 PM data value
);

  // =====
  // Elaboration check
  if (nfca_pkg::NUM_WORDS != 11) begin : g_chk
    $error("Word table length must match the load sequence");
  end

  // =====
  // State
  typedef struct packed {
    nfca_pkg::nfca_state_t       fsm;         // Loader state
    logic [3:0]                  idx;         // Current word index
    logic                        req;         // NVM request
    logic [nfca_pkg::AW-1:0]     addr;        // NVM address
    logic                        port;        // Network port select
    logic                        warn;        // Image marker bits wrong
    logic [3:0]                  boot;        // Disable bits 15:12
    logic [23:0]                 kcls;        // Keyboard-style class
    logic [23:0]                 bcls;        // Block-transfer class
    logic [15:0]                 udev;        // USB function device ID
    logic [15:0]                 usub;        // USB function subsystem ID
    logic [15:0]                 bdev;        // Block-transfer device ID
    logic [15:0]                 bsub;        // Block-transfer subsystem ID
    logic [4:0]                  ud0;         // USB active power
    logic [4:0]                  ud3;         // USB sleep power
    logic [4:0]                  bd0;         // Block-transfer active power
    logic [4:0]                  bd3;         // Block-transfer sleep power
    logic [4:0]                  upm;         // USB PM data output
    logic [4:0]                  bpm;         // Block-transfer PM data output
    logic                        ready;       // Load done
    logic                        pready;      // APB ready
    logic                        pslverr;     // APB error
    logic [31:0]                 prdata;      // APB read data
  } nfca_st_t;

  nfca_st_t st_r;                             // Registered state
  nfca_st_t st_nxt;                           // Next state

  // Reset image: defaults everywhere, load starts right after release
  localparam nfca_st_t ST_RST = '{
    fsm:     nfca_pkg::NFCA_IDLE,
    idx:     4'h0,
    req:     1'b0,
    addr:    '0,
    port:    1'b0,
    warn:    1'b0,
    boot:    nfca_pkg::BOOT_DEF,
    kcls:    nfca_pkg::KBD_CLS_DEF,
    bcls:    nfca_pkg::BT_CLS_DEF,
    udev:    USB_DEV_ID_DEF,
    usub:    nfca_pkg::SUB_DEF,
    bdev:    BT_DEV_ID_DEF,
    bsub:    nfca_pkg::SUB_DEF,
    ud0:     nfca_pkg::PWR_DEF,
    ud3:     nfca_pkg::PWR_DEF,
    bd0:     nfca_pkg::PWR_DEF,
    bd3:     nfca_pkg::PWR_DEF,
    upm:     nfca_pkg::PWR_DEF,
    bpm:     nfca_pkg::PWR_DEF,
    ready:   1'b0,
    pready:  1'b0,
    pslverr: 1'b0,
    prdata:  32'h0000_0000
  };

  // =====
  // Helpers
  logic          apb_setup;                   // Setup phase of a transfer
  logic          apb_wr;                      // Write completes this edge
  logic          reload;                      // Software asks for a fresh load
  logic [31:0]   rd_mux;                      // Read data selection
  logic          hit;                         // Address is mapped

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && st_r.pready && pwrite;
  assign reload    = apb_wr && (paddr == nfca_pkg::A_CTRL) && pwdata[nfca_pkg::C_RELOAD];

  // =====
  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    unique case (paddr)
      nfca_pkg::A_CTRL: begin
        rd_mux[nfca_pkg::C_PORT] = st_r.port;
      end
      nfca_pkg::A_STAT: begin
        rd_mux[2:0] = {st_r.warn, (st_r.fsm != nfca_pkg::NFCA_READY), st_r.ready};
      end
      nfca_pkg::A_BOOT: begin
        rd_mux[3:0] = st_r.boot;
      end
      nfca_pkg::A_KCLS: begin
        rd_mux[23:0] = st_r.kcls;
      end
      nfca_pkg::A_BCLS: begin
        rd_mux[23:0] = st_r.bcls;
      end
      nfca_pkg::A_UIDS: begin
        rd_mux = {st_r.usub, st_r.udev};
      end
      nfca_pkg::A_BIDS: begin
        rd_mux = {st_r.bsub, st_r.bdev};
      end
      nfca_pkg::A_PWR: begin
        rd_mux[19:0] = {st_r.bd3, st_r.bd0, st_r.ud3, st_r.ud0};
      end
      default: begin
        hit = 1'b0;                           // Unmapped: error, reads zero
      end
    endcase
  end

  // =====
  // Next-state logic
  always_comb begin
    st_nxt = st_r;

    // APB: ready is raised for the first access cycle, so no wait states
    if (apb_setup) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = !hit;
      st_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
    end
    // Port select only changes while idle or ready, never mid-load
    if (apb_wr && (paddr == nfca_pkg::A_CTRL) && (st_r.fsm != nfca_pkg::NFCA_FETCH)) begin
      st_nxt.port = pwdata[nfca_pkg::C_PORT];
    end

    // PM data follows the power state of each function
    st_nxt.upm = usb_in_d3 ? st_r.ud3 : st_r.ud0;
    st_nxt.bpm = bt_in_d3 ? st_r.bd3 : st_r.bd0;

    unique case (st_r.fsm)
      nfca_pkg::NFCA_IDLE: begin
        // Launch the first read; a reload restarts here too
        st_nxt.fsm   = nfca_pkg::NFCA_FETCH;
        st_nxt.idx   = 4'h0;
        st_nxt.req   = 1'b1;
        st_nxt.warn  = 1'b0;
        st_nxt.ready = 1'b0;
        st_nxt.addr  = st_nxt.port ? nfca_pkg::ADDR_P1[0] : nfca_pkg::ADDR_P0[0];
      end
      nfca_pkg::NFCA_FETCH: begin
        if (nvm_ack) begin
          // Fields update in place; hosts wait for ready before trusting them
          unique case (st_r.idx)
            nfca_pkg::W_BOOT: begin
              st_nxt.boot = nvm_data[nfca_pkg::B_KBD_OFF -: 4];
            end
            nfca_pkg::W_KCL: begin
              st_nxt.kcls[15:0] = nvm_data;
            end
            nfca_pkg::W_KCH: begin
              st_nxt.kcls[23:16] = nvm_data[7:0];
            end
            nfca_pkg::W_UDEV: begin
              st_nxt.udev = nvm_data;
            end
            nfca_pkg::W_BDEV: begin
              st_nxt.bdev = nvm_data;
            end
            nfca_pkg::W_USUB: begin
              st_nxt.usub = nvm_data;
            end
            nfca_pkg::W_BSUB: begin
              st_nxt.bsub = nvm_data;
            end
            nfca_pkg::W_BCL: begin
              st_nxt.bcls[15:0] = nvm_data;
            end
            nfca_pkg::W_BCH: begin
              st_nxt.bcls[23:16] = nvm_data[7:0];
            end
            nfca_pkg::W_PD0: begin
              st_nxt.ud0  = nvm_data[nfca_pkg::PW_USB_LO +: 5];
              st_nxt.bd0  = nvm_data[nfca_pkg::PW_BT_LO +: 5];
              // Flag an image that breaks its own marker bits
              st_nxt.warn = !nvm_data[nfca_pkg::PW_MARK] ||
                            (nvm_data[nfca_pkg::PW_RSV_LO +: 5] != 5'h00);
            end
            nfca_pkg::W_PD3: begin
              st_nxt.ud3 = nvm_data[nfca_pkg::PW_USB_LO +: 5];
              st_nxt.bd3 = nvm_data[nfca_pkg::PW_BT_LO +: 5];
            end
            default: begin
              st_nxt.req = 1'b0;              // Index out of range cannot occur
            end
          endcase
          if (st_r.idx == nfca_pkg::W_LAST) begin
            st_nxt.req   = 1'b0;
            st_nxt.fsm   = nfca_pkg::NFCA_READY;
            st_nxt.ready = 1'b1;
          end else begin
            st_nxt.idx  = st_r.idx + 4'h1;
            st_nxt.addr = st_r.port ? nfca_pkg::ADDR_P1[st_r.idx + 4'h1]
                                    : nfca_pkg::ADDR_P0[st_r.idx + 4'h1];
          end
        end
      end
      nfca_pkg::NFCA_READY: begin
        // A reload keeps current values until the new words arrive
        if (reload) begin
          st_nxt.fsm   = nfca_pkg::NFCA_IDLE;
          st_nxt.ready = 1'b0;
        end
      end
      default: begin
        st_nxt.fsm = nfca_pkg::NFCA_IDLE;
      end
    endcase
  end

  // =====
  // State register, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // =====
  // Outputs straight from the state register
  assign pready                = st_r.pready;
  assign pslverr               = st_r.pslverr;
  assign prdata                = st_r.prdata;
  assign nvm_req               = st_r.req;
  assign nvm_addr              = st_r.addr;
  assign cfg_ready             = st_r.ready;
  assign kbd_style_rom_bar_off = st_r.boot[3];
  assign storage_rom_bar_off   = st_r.boot[2];
  assign net_rom_bar_off       = st_r.boot[1];
  assign net_flash_window_off  = st_r.boot[0];
  assign kbd_class_code        = st_r.kcls;
  assign bt_class_code         = st_r.bcls;
  assign usb_dev_id            = st_r.udev;
  assign usb_subsys_id         = st_r.usub;
  assign bt_dev_id             = st_r.bdev;
  assign bt_subsys_id          = st_r.bsub;
  assign usb_pm_data           = st_r.upm;
  assign bt_pm_data            = st_r.bpm;

endmodule

// ===== dv/nfca_nvm_model.sv
// Behavioural NVM image answering the autoloader's word reads
`timescale 1ns/1ps

module nfca_nvm_model (
  input  wire logic        pclk,     // Clock
  input  wire logic        presetn,  // Reset, active low
  input  wire logic        nvm_req,  // Word wanted
  input  wire logic [8:0]  nvm_addr, // Word address
  input  wire logic [3:0]  slow,     // Extra wait cycles
  output logic             nvm_ack,  // Data valid pulse
  output logic [15:0]      nvm_data  // Word read
);
  // =====
  // Image and answer timing
  logic [15:0] mem [512]; // Image, filled by the bench
  int          cnt;       // Cycles waited on the current word

  // Answer after slow cycles; the data line toggles outside acks so a stale word never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_ack  <= 1'b0;
      nvm_data <= 16'h5a5a;
      cnt      <= 0;
    end else if (!nvm_ack && nvm_req && cnt >= slow) begin
      nvm_ack  <= 1'b1;
      nvm_data <= mem[nvm_addr];
      cnt      <= 0;
    end else begin
      nvm_ack  <= 1'b0;
      nvm_data <= ~nvm_data;
      cnt      <= nvm_ack ? 0 : cnt + 1;
    end
  end
endmodule

// ===== dv/nfca_props.sv
// Concurrent checks on the autoloader's ports
`timescale 1ns/1ps

module nfca_props (
  input wire logic        pclk,                  // Clock
  input wire logic        presetn,               // Reset, active low
  input wire logic        ce,                    // Clock enable
  input wire logic        psel,                  // APB select
  input wire logic        penable,               // APB access
  input wire logic        pwrite,                // APB write
  input wire logic [7:0]  paddr,                 // APB address
  input wire logic [31:0] pwdata,                // APB write data
  input wire logic        pready,                // APB ready
  input wire logic        pslverr,               // APB error
  input wire logic        nvm_req,               // Word wanted
  input wire logic [8:0]  nvm_addr,              // Word address
  input wire logic        nvm_ack,               // Word valid
  input wire logic [15:0] nvm_data,              // Word read
  input wire logic        usb_in_d3,             // USB function in D3
  input wire logic        bt_in_d3,              // Block-transfer in D3
  input wire logic        cfg_ready,             // Load finished
  input wire logic        kbd_style_rom_bar_off, // Keyboard-style ROM BAR off
  input wire logic        net_flash_window_off,  // Flash window off
  input wire logic [23:0] kbd_class_code,        // Keyboard-style class
  input wire logic [23:0] bt_class_code,         // Block-transfer class
  input wire logic [15:0] usb_subsys_id,         // Function 5 subsystem
  input wire logic [4:0]  usb_pm_data,           // Function 5 PM data
  input wire logic [4:0]  bt_pm_data             // Function 7 PM data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // =====
  // Power words as they cross the NVM port
  logic [15:0] act_r; // Last active power word
  logic [15:0] slp_r; // Last sleep power word

  // Capture on accepted words only, as the design does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r <= 16'h0000;
      slp_r <= 16'h0000;
    end else if (ce && nvm_req && nvm_ack) begin
      act_r <= (nvm_addr == 9'h059 || nvm_addr == 9'h119) ? nvm_data : act_r;
      slp_r <= (nvm_addr == 9'h05a || nvm_addr == 9'h11a) ? nvm_data : slp_r;
    end
  end

  // =====
  // Reload steps
  sequence s_reload_wr;
    psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[0] && cfg_ready;
  endsequence
  sequence s_refetch;
    !cfg_ready ##1 nvm_req && nvm_addr == 9'h04c;
  endsequence

  // =====
  // Assertions
  chk_pready_pulse: assert property (psel && !penable && ce |=> pready ##1 !pready)
    else $error("pready is not a one-cycle answer");
  chk_err_map: assert property (pready |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'b00))
    else $error("pslverr does not match the address map");
  chk_load_start: assert property ($rose(presetn) |=> nvm_req && nvm_addr == 9'h04c)
    else $error("load did not start at the boot word");
  chk_reset_defaults: assert property ($rose(presetn) |-> kbd_style_rom_bar_off && !net_flash_window_off
    && kbd_class_code == 24'h0c0701 && bt_class_code == 24'h0c0702 && usb_subsys_id == 16'h0000 && !cfg_ready)
    else $error("fields not at defaults before load");
  chk_addr_hold: assert property (nvm_req && !nvm_ack && ce |=> nvm_req && $stable(nvm_addr))
    else $error("word request moved before ack");
  chk_port_order: assert property (nvm_req && nvm_ack && ce && nvm_addr[8] |=> !nvm_req || nvm_addr[8])
    else $error("port 1 load left the high word range");
  chk_last_word: assert property (nvm_req && nvm_ack && ce && (nvm_addr == 9'h05a || nvm_addr == 9'h11a) |=> cfg_ready && !nvm_req)
    else $error("load did not finish after the last word");
  chk_reload_seq: assert property (s_reload_wr |=> s_refetch)
    else $error("reload did not restart the fetch");
  chk_usb_power: assert property (cfg_ready && $past(cfg_ready) && $past(ce)
    |-> usb_pm_data == ($past(usb_in_d3) ? slp_r[14:10] : act_r[14:10]))
    else $error("usb power data wrong for its state");
  chk_bt_power: assert property (cfg_ready && $past(cfg_ready) && $past(ce)
    |-> bt_pm_data == ($past(bt_in_d3) ? slp_r[4:0] : act_r[4:0]))
    else $error("block-transfer power data wrong for its state");
endmodule

bind nfca_top nfca_props u_props (.*);

// ===== dv/nvm_function_config_autoload_tb.sv
// Self-checking bench for the NVM function configuration autoloader
`timescale 1ns/1ps

module nvm_function_config_autoload_tb;
  // =====
  // Signals
  localparam logic [15:0] UDEF = 16'h0a5a; // Arbitrary ID default
  localparam logic [15:0] BDEF = 16'h0a5b; // Arbitrary ID default
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1; // Clock, reset, enable
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request
  logic [7:0]  paddr = 8'h00;    // APB address
  logic [31:0] pwdata = 32'h0;   // APB write data
  logic        usb_in_d3 = 1'b0, bt_in_d3 = 1'b0; // Power states
  logic [3:0]  slow = 4'h0;      // NVM wait cycles
  logic        pready, pslverr, nvm_req, nvm_ack, cfg_ready; // Handshakes
  logic [31:0] prdata, rd;       // Read data
  logic [8:0]  nvm_addr;         // NVM word address
  logic [15:0] nvm_data, usb_dev_id, usb_subsys_id, bt_dev_id, bt_subsys_id; // Words and IDs
  logic        kbd_style_rom_bar_off, storage_rom_bar_off, net_rom_bar_off, net_flash_window_off; // BAR bits
  logic [23:0] kbd_class_code, bt_class_code; // Class codes
  logic [4:0]  usb_pm_data, bt_pm_data;       // PM data values
  logic [15:0] img [11];         // Expected image in load order
  logic        prt = 1'b0, er;   // Expected port, read error
  int          idx, failures, samples_checked; // Word index, counters

  nfca_top #(.USB_DEV_ID_DEF(UDEF), .BT_DEV_ID_DEF(BDEF)) uut (.*);
  nfca_nvm_model nvm (.*);

  // Clock at 200 MHz
  always #2.5 pclk = ~pclk;

  // =====
  // Tasks
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready, one idle edge after
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) failures++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (cfg_ready !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    check("cfg_ready", cfg_ready, 1'b1);
    @(posedge pclk);
  endtask

  // Random image for one port; the active power word keeps its marker and zero bits
  task automatic fill(input logic p);
    for (int i = 0; i < 11; i++) begin
      img[i] = 16'($urandom);
      if (i == 9) img[i] = {1'b1, img[i][14:10], 5'h00, img[i][4:0]};
      nvm.mem[p ? nfca_pkg::ADDR_P1[i] : nfca_pkg::ADDR_P0[i]] = img[i];
    end
    prt = p;
    idx = 0;
  endtask

  task automatic set_defaults();
    img = '{16'he000, 16'h0701, 16'h000c, UDEF, BDEF, 16'h0000, 16'h0000, 16'h0702, 16'h000c, 16'h0000, 16'h0000};
    prt = 1'b0;
  endtask

  task automatic chk_fields(input logic rdy);
    check("ready", cfg_ready, rdy);
    check("bar_bits", {kbd_style_rom_bar_off, storage_rom_bar_off, net_rom_bar_off, net_flash_window_off},
          img[0][15:12]);
    check("kbd_class", kbd_class_code, {img[2][7:0], img[1]});
    check("bt_class", bt_class_code, {img[8][7:0], img[7]});
    check("usb_ids", {usb_subsys_id, usb_dev_id}, {img[5], img[3]});
    check("bt_ids", {bt_subsys_id, bt_dev_id}, {img[6], img[4]});
    for (int k = 0; k < 4; k++) begin
      usb_in_d3 <= k[0];
      bt_in_d3 <= k[1];
      repeat (2) @(posedge pclk);
      check("usb_pm", usb_pm_data, k[0] ? img[10][14:10] : img[9][14:10]);
      check("bt_pm", bt_pm_data, k[1] ? img[10][4:0] : img[9][4:0]);
    end
  endtask

  function automatic logic [31:0] reg_exp(logic [7:0] a);
    case (a)
      8'h00: return {30'h0, prt, 1'b0};
      8'h04: return 32'h1;
      8'h08: return {28'h0, img[0][15:12]};
      8'h0c: return {8'h0, img[2][7:0], img[1]};
      8'h10: return {8'h0, img[8][7:0], img[7]};
      8'h14: return {img[5], img[3]};
      8'h18: return {img[6], img[4]};
      8'h1c: return {12'h0, img[10][4:0], img[9][4:0], img[10][14:10], img[9][14:10]};
      default: return 32'h0;
    endcase
  endfunction

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // =====
  // Word order seen on the NVM port
  always @(posedge pclk) begin
    if (presetn && ce && nvm_req && nvm_ack) begin
      check("nvm_addr", 32'(nvm_addr), 32'(prt ? nfca_pkg::ADDR_P1[idx] : nfca_pkg::ADDR_P0[idx]));
      idx = idx + 1;
    end
  end

  // Watchdog, far beyond the expected run
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end

  // =====
  // Main sequence
  initial begin
    void'($urandom(32'h7e4d515a));
    set_defaults();
    repeat (4) @(posedge pclk);
    chk_fields(1'b0);
    fill(1'b0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check("early_class", kbd_class_code, 32'h0c0701);
    wait_ready();
    chk_fields(1'b1);
    // Register map readback, unmapped places included
    for (int a = 0; a < 10; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      check("prdata", rd, reg_exp(8'(a * 4)));
      check("pslverr", er, a > 7);
    end
    apb(1'b1, 8'h24, 32'hffffffff);
    check("wr_err", er, 1'b1);
    // Reload from port 1 with a slow NVM; a port change mid-load is refused
    apb(1'b1, 8'h00, 32'h2);
    fill(1'b1);
    slow <= 4'h3;
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check("busy", rd, 32'h2);
    wait_ready();
    chk_fields(1'b1);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl", rd, 32'h2);
    // Clock enable low freezes the power output
    ce <= 1'b0;
    usb_in_d3 <= 1'b0;
    repeat (3) @(posedge pclk);
    check("frozen_pm", usb_pm_data, img[10][14:10]);
    ce <= 1'b1;
    repeat (2) @(posedge pclk);
    check("thawed_pm", usb_pm_data, img[9][14:10]);
    // Reset in mid-load brings defaults back, then port 0 loads again
    fill(1'b1);
    apb(1'b1, 8'h00, 32'h3);
    repeat (10) @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    set_defaults();
    chk_fields(1'b0);
    fill(1'b0);
    slow <= 4'h1;
    presetn <= 1'b1;
    @(posedge pclk);
    wait_ready();
    chk_fields(1'b1);
    tally_and_finish();
  end
endmodule
